// ===== jcf_defs.svh
// Constants for the code fetch sequencer and reset control
// What this block and its host do
// [RULE1] On start, fetch the first field from the first table entry's fragments.
// [RULE2] After a field finishes, mark its entry done, interrupt, move to next field.
// [RULE3] Each field start reads the next entry; flag 0 means fetch that buffer.
// [RULE4] Flag 1 at field start means replay the most recent available buffer.
// [RULE5] Host prepares four buffers, both tables and the code before starting.
// [RULE6] Host writes the table base pointer before starting.
// [RULE7] On interrupt host refills done buffers and clears their flags.
// [RULE8] Above the code FIFO threshold, no new bus request for code.
// [RULE9] With early release set, drop the bus request right after grant.
// [RULE10] Host should use latency 48 and threshold 20, or single fragments.
// [RULE11] Hardware reset returns every state machine and register to default.
// [RULE12] After reset all eight general purpose lines are undriven inputs.
// [RULE13] Guest and serial lines float during hardware reset, then take idle states.
// [RULE14] Hardware reset clears the software reset bit; device waits until it is 1.
// [RULE15] Software reset holds everything default except its bit and the host interface.
// [RULE16] During software reset answer as target but start no master transfers.
// [RULE17] Application register writes take effect only once the software reset bit is 1.
// [RULE18] Compression reset bit resets only the compression sequencing and controls.
// [RULE19] Host holds compression reset while loading parameters and before starting.
// [RULE20] Configuration space has 256 bytes, first 64 the standard header.
// [RULE21] Configuration cycles are answered only when the select input is high.
// [RULE22] Unimplemented configuration addresses read as zero.
// [RULE23] Entry bit 0 is the flag; bits 31:2 point to the fragment table.
// [RULE24] Fragment entry is address then length word; length bit 0 marks final.
// [RULE25] Entries are walked cyclically; next fragment after each length is used.
`ifndef JCF_DEFS_SVH
`define JCF_DEFS_SVH
`define JCF_APP_BASE 2'h0
`define JCF_APP_THR 2'h1
`define JCF_APP_CTRL 2'h2
`define JCF_CTRL_EARLY 0
`define JCF_CTRL_PRESET 1
`define JCF_CTRL_GO 2
`define JCF_CFG_ID 6'h00
`define JCF_CFG_CMD 6'h01
`define JCF_CMD_MEM 1
`define JCF_CMD_MASTER 2
`define JCF_DEV_ID 16'h5a5a
`define JCF_VEN_ID 16'ha5a5
`define JCF_FLAG_BIT 0
`define JCF_FINAL_BIT 0
`define JCF_WORD_BYTES 32'h4
`define JCF_FRAG_BYTES 32'h8
`define JCF_STAT_DONE 32'h0000_0001
`endif

// ===== jcf_pkg.sv
// Types for the code fetch sequencer
package jcf_pkg;
   typedef enum logic [2:0] {
      S_IDLE, S_WAIT_FIELD, S_RD_ENTRY, S_RD_FADDR, S_RD_FLEN, S_XFER, S_WAIT_DONE, S_WR_STAT
   } jcf_state_t;

   typedef struct packed {
      jcf_state_t state;
      logic sw_bit;
      logic master_en;
      logic mem_en;
      logic [31:0] base;
      logic [7:0] thr;
      logic early;
      logic preset;
      logic [1:0] idx;
      logic have_buf;
      logic replay;
      logic [31:0] cur_buf;
      logic [31:0] frag_ptr;
      logic [31:0] addr;
      logic [31:0] cnt;
      logic final_f;
      logic granted;
      logic bus_req;
      logic mem_req;
      logic mem_we;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic [31:0] code_data;
      logic code_valid;
      logic irq;
      logic [31:0] cfg_rdata;
      logic cfg_ack;
      logic io_oe;
      logic [7:0] gpio_oe;
   } jcf_st_t;
endpackage

// ===== jcf_top.sv
// Code fetch sequencer for decompression with device reset control
`timescale 1ns/10ps
`include "jcf_defs.svh"
module jcf_top (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sw_reg_wr,
   input wire logic sw_reg_wdata,
   input wire logic app_wr,
   input wire logic [1:0] app_addr,
   input wire logic [31:0] app_wdata,
   input wire logic cfg_sel,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   output logic bus_req,
   input wire logic bus_gnt,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic [7:0] code_fifo_level,
   output logic [31:0] code_data,
   output logic code_valid,
   input wire logic field_start,
   input wire logic field_done,
   output logic irq,
   output logic [1:0] entry_index,
   output logic software_reset_bit,
   output logic guest_bus_oe,
   output logic serial_oe,
   output logic [7:0] gpio_oe
);
   jcf_pkg::jcf_st_t st;
   jcf_pkg::jcf_st_t next_st;
   logic go;
   logic dma_ok;
   logic want;
   logic issue;
   logic ack;

   function automatic logic [31:0] entry_addr(input logic [31:0] base, input logic [1:0] idx);
      entry_addr = base + {28'h0, idx, 2'b00};
   endfunction

   // Clears the sequencer; host interface fields always survive
   function automatic jcf_pkg::jcf_st_t clear_seq(input jcf_pkg::jcf_st_t s, input logic keep_app);
      jcf_pkg::jcf_st_t r;
      r = '0;
      r.sw_bit = s.sw_bit;
      r.master_en = s.master_en;
      r.mem_en = s.mem_en;
      r.cfg_rdata = s.cfg_rdata;
      r.cfg_ack = s.cfg_ack;
      r.io_oe = s.io_oe;
      if (keep_app) begin
         r.base = s.base;
         r.thr = s.thr;
         r.early = s.early;
         r.preset = s.preset;
      end
      clear_seq = r;
   endfunction

   always_comb begin
      next_st = st;
      next_st.irq = 1'b0;
      next_st.code_valid = 1'b0;
      next_st.cfg_ack = 1'b0;
      next_st.io_oe = 1'b1; // [RULE13]
      next_st.gpio_oe = 8'h00; // [RULE12]
      go = 1'b0;
      if (sw_reg_wr) begin
         next_st.sw_bit = sw_reg_wdata;
      end
      // Writes before the bit is set are lost, not deferred
      if (app_wr && st.sw_bit) begin // [RULE17]
         case (app_addr)
            `JCF_APP_BASE: next_st.base = {app_wdata[31:2], 2'b00};
            `JCF_APP_THR: next_st.thr = app_wdata[7:0];
            `JCF_APP_CTRL: begin
               next_st.early = app_wdata[`JCF_CTRL_EARLY];
               next_st.preset = app_wdata[`JCF_CTRL_PRESET];
               go = app_wdata[`JCF_CTRL_GO] && !app_wdata[`JCF_CTRL_PRESET];
            end
            default: ;
         endcase
      end
      if (cfg_sel && (cfg_rd || cfg_wr)) begin // [RULE21]
         next_st.cfg_ack = 1'b1;
         next_st.cfg_rdata = 32'h0; // [RULE22]
         if (cfg_addr[7:2] == `JCF_CFG_ID) begin // [RULE20]
            next_st.cfg_rdata = {`JCF_DEV_ID, `JCF_VEN_ID};
         end else if (cfg_addr[7:2] == `JCF_CFG_CMD) begin
            next_st.cfg_rdata[`JCF_CMD_MASTER] = st.master_en;
            next_st.cfg_rdata[`JCF_CMD_MEM] = st.mem_en;
            if (cfg_wr) begin
               next_st.master_en = cfg_wdata[`JCF_CMD_MASTER];
               next_st.mem_en = cfg_wdata[`JCF_CMD_MEM];
            end
         end
         if (cfg_wr) begin
            next_st.cfg_rdata = 32'h0;
         end
      end
      dma_ok = st.sw_bit && st.master_en && !st.preset; // [RULE16]
      want = (st.state == jcf_pkg::S_RD_ENTRY) || (st.state == jcf_pkg::S_RD_FADDR) ||
             (st.state == jcf_pkg::S_RD_FLEN) || (st.state == jcf_pkg::S_WR_STAT) ||
             ((st.state == jcf_pkg::S_XFER) && (code_fifo_level <= st.thr)); // [RULE8]
      want = want && dma_ok;
      next_st.granted = bus_gnt && (st.granted || st.bus_req);
      // Early release leaves burst length to the latency timer
      next_st.bus_req = want && !(st.early && (bus_gnt || st.granted)); // [RULE9]
      issue = want && bus_gnt && !st.mem_req;
      ack = st.mem_req && mem_ack;
      if (ack) begin
         next_st.mem_req = 1'b0;
         next_st.mem_we = 1'b0;
      end
      if (issue) begin
         next_st.mem_req = 1'b1;
         next_st.mem_we = (st.state == jcf_pkg::S_WR_STAT);
         next_st.mem_wdata = `JCF_STAT_DONE; // [RULE2]
         if ((st.state == jcf_pkg::S_RD_ENTRY) || (st.state == jcf_pkg::S_WR_STAT)) begin
            next_st.mem_addr = entry_addr(st.base, st.idx); // [RULE6]
         end else if (st.state == jcf_pkg::S_RD_FLEN) begin
            next_st.mem_addr = st.frag_ptr + `JCF_WORD_BYTES; // [RULE24]
         end else if (st.state == jcf_pkg::S_XFER) begin
            next_st.mem_addr = st.addr;
         end else begin
            next_st.mem_addr = st.frag_ptr;
         end
      end
      unique case (st.state)
         jcf_pkg::S_IDLE: begin
            if (go) begin
               next_st.idx = 2'h0; // [RULE1]
               next_st.state = jcf_pkg::S_RD_ENTRY;
            end
         end
         jcf_pkg::S_WAIT_FIELD: begin
            if (field_start) begin
               next_st.state = jcf_pkg::S_RD_ENTRY; // [RULE3]
            end
         end
         jcf_pkg::S_RD_ENTRY: begin
            if (ack) begin
               if (!mem_rdata[`JCF_FLAG_BIT]) begin // [RULE3] [RULE23]
                  next_st.cur_buf = {mem_rdata[31:2], 2'b00};
                  next_st.frag_ptr = {mem_rdata[31:2], 2'b00};
                  next_st.have_buf = 1'b1;
                  next_st.replay = 1'b0;
                  next_st.state = jcf_pkg::S_RD_FADDR;
               end else if (st.have_buf) begin // [RULE4]
                  next_st.frag_ptr = st.cur_buf;
                  next_st.replay = 1'b1;
                  next_st.state = jcf_pkg::S_RD_FADDR;
               end else begin
                  // Nothing played yet, so nothing to replay
                  next_st.state = jcf_pkg::S_WAIT_FIELD;
               end
            end
         end
         jcf_pkg::S_RD_FADDR: begin
            if (ack) begin
               next_st.addr = {mem_rdata[31:2], 2'b00}; // [RULE24]
               next_st.state = jcf_pkg::S_RD_FLEN;
            end
         end
         jcf_pkg::S_RD_FLEN: begin
            if (ack) begin
               next_st.cnt = {mem_rdata[31:1], 1'b0};
               next_st.final_f = mem_rdata[`JCF_FINAL_BIT]; // [RULE24]
               next_st.frag_ptr = st.frag_ptr + `JCF_FRAG_BYTES; // [RULE25]
               if (mem_rdata[31:1] != 31'h0) begin
                  next_st.state = jcf_pkg::S_XFER;
               end else if (mem_rdata[`JCF_FINAL_BIT]) begin
                  next_st.state = jcf_pkg::S_WAIT_DONE;
               end else begin
                  next_st.state = jcf_pkg::S_RD_FADDR;
               end
            end
         end
         jcf_pkg::S_XFER: begin
            if (ack) begin
               next_st.code_data = mem_rdata;
               next_st.code_valid = 1'b1;
               next_st.addr = st.addr + `JCF_WORD_BYTES;
               next_st.cnt = st.cnt - 32'h1;
               if (st.cnt == 32'h1) begin // [RULE25]
                  next_st.state = st.final_f ? jcf_pkg::S_WAIT_DONE : jcf_pkg::S_RD_FADDR;
               end
            end
         end
         jcf_pkg::S_WAIT_DONE: begin
            if (field_done) begin
               // A replayed buffer is already marked; entry is read again next field
               next_st.state = st.replay ? jcf_pkg::S_WAIT_FIELD : jcf_pkg::S_WR_STAT;
            end
         end
         jcf_pkg::S_WR_STAT: begin
            if (ack) begin
               next_st.irq = 1'b1; // [RULE2]
               next_st.idx = st.idx + 2'h1; // [RULE25]
               next_st.state = jcf_pkg::S_WAIT_FIELD;
            end
         end
      endcase
      if (!st.sw_bit) begin
         next_st = clear_seq(next_st, 1'b0); // [RULE15]
      // A write that lifts process reset together with go must not lose the start
      end else if (st.preset && next_st.preset) begin
         next_st = clear_seq(next_st, 1'b1); // [RULE18]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0; // [RULE11] [RULE14]
      end else begin
         st <= next_st;
      end
   end

   assign cfg_rdata = st.cfg_rdata;
   assign cfg_ack = st.cfg_ack;
   assign bus_req = st.bus_req;
   assign mem_req = st.mem_req;
   assign mem_we = st.mem_we;
   assign mem_addr = st.mem_addr;
   assign mem_wdata = st.mem_wdata;
   assign code_data = st.code_data;
   assign code_valid = st.code_valid;
   assign irq = st.irq;
   assign entry_index = st.idx;
   assign software_reset_bit = st.sw_bit;
   assign guest_bus_oe = st.io_oe;
   assign serial_oe = st.io_oe;
   assign gpio_oe = st.gpio_oe;

   a_first_entry: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
      (st.state == jcf_pkg::S_IDLE && go && st.sw_bit) |=>
      (st.state == jcf_pkg::S_RD_ENTRY && st.idx == 2'h0))
      else $error("start did not read entry zero");
   a_irq_after_mark: assert property (@(posedge core_clk) disable iff (rst) // [RULE2]
      st.irq |-> $past(st.state == jcf_pkg::S_WR_STAT && st.mem_req && st.mem_we && mem_ack))
      else $error("interrupt without status write");
   a_fresh_buffer: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
      (st.state == jcf_pkg::S_RD_ENTRY && ack && !mem_rdata[0] && dma_ok) |=>
      (st.cur_buf == {$past(mem_rdata[31:2]), 2'b00} && !st.replay))
      else $error("free buffer not taken");
   a_replay_last: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
      (st.state == jcf_pkg::S_RD_ENTRY && ack && mem_rdata[0] && st.have_buf && dma_ok) |=>
      (st.replay && st.frag_ptr == $past(st.cur_buf) && st.state == jcf_pkg::S_RD_FADDR))
      else $error("busy entry not replayed");
   a_thr_stall: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
      (st.state == jcf_pkg::S_XFER && !st.mem_req && code_fifo_level > st.thr) |=>
      (!st.mem_req && !st.bus_req))
      else $error("code request above threshold");
   a_early_drop: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
      (st.early && st.bus_req && bus_gnt) |=> !st.bus_req)
      else $error("request held after grant");
   a_gpio_input: assert property (@(posedge core_clk) disable iff (rst) // [RULE12]
      gpio_oe == 8'h00)
      else $error("general purpose line driven");
   a_sw_hold: assert property (@(posedge core_clk) disable iff (rst) // [RULE14]
      (!st.sw_bit && !sw_reg_wr) |=> !st.sw_bit)
      else $error("software reset bit left zero alone");
   a_sw_quiet: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
      !st.sw_bit |=> (!st.mem_req && !st.bus_req && st.state == jcf_pkg::S_IDLE))
      else $error("master activity in software reset");
   a_preset_idle: assert property (@(posedge core_clk) disable iff (rst) // [RULE18]
      (st.preset && st.sw_bit && !app_wr) |=> (st.state == jcf_pkg::S_IDLE && !st.mem_req))
      else $error("sequencer active during process reset");
   a_cfg_answer: assert property (@(posedge core_clk) disable iff (rst) // [RULE21]
      st.cfg_ack |-> $past(cfg_sel && (cfg_rd || cfg_wr)))
      else $error("config answer without select");
   a_cfg_zero: assert property (@(posedge core_clk) disable iff (rst) // [RULE22]
      (cfg_sel && cfg_rd && cfg_addr[7:3] != 5'h00) |=> (st.cfg_ack && st.cfg_rdata == 32'h0))
      else $error("unmapped config read not zero");
   a_entry_wrap: assert property (@(posedge core_clk) disable iff (rst) // [RULE25]
      (st.state == jcf_pkg::S_WR_STAT && ack && st.idx == 2'h3 && st.sw_bit && !st.preset) |=>
      (st.idx == 2'h0))
      else $error("entry index did not wrap");
endmodule

// ===== jcf_host_mem.sv
// Host memory and bus arbiter model facing the code fetch sequencer
`timescale 1ns/10ps
module jcf_host_mem (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [1:0] lat,
   input wire logic bus_req,
   output logic bus_gnt,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   // Holds the entry table, fragment tables and code prepared by the host
   logic [31:0] mem [0:255];
   logic [1:0] wait_cnt;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_gnt <= 1'b0;
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         wait_cnt <= 2'h0;
      end else begin
         // Grant stays parked on the device while an access is open
         bus_gnt <= bus_req | mem_req;
         mem_ack <= 1'b0;
         // No answer in this cycle: read data shows a changing pattern
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            if (wait_cnt < lat) begin
               wait_cnt <= wait_cnt + 2'h1;
            end else begin
               wait_cnt <= 2'h0;
               mem_ack <= 1'b1;
               if (mem_we) begin
                  mem[mem_addr[9:2]] <= mem_wdata;
               end else begin
                  mem_rdata <= mem[mem_addr[9:2]];
               end
            end
         end else begin
            wait_cnt <= 2'h0;
         end
      end
   end
endmodule

// ===== jcf_top_test.sv
// Self-checking bench for the code fetch sequencer and reset control
`timescale 1ns/10ps
`include "jcf_defs.svh"
module jcf_top_test;
   logic core_clk, rst, sw_reg_wr, sw_reg_wdata, app_wr, cfg_sel, cfg_rd, cfg_wr;
   logic [1:0] app_addr, entry_index, lat, gnt_hist;
   logic [31:0] app_wdata, cfg_wdata, cfg_rdata, mem_addr, mem_wdata, mem_rdata, code_data;
   logic [7:0] cfg_addr, code_fifo_level, gpio_oe;
   logic cfg_ack, bus_req, bus_gnt, mem_req, mem_we, mem_ack, code_valid, field_start;
   logic field_done, irq, software_reset_bit, guest_bus_oe, serial_oe, early_mode, seen, ack_v;
   logic [31:0] rd_v;
   logic [31:0] dat [4] = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003, 32'h4444_0004};
   int miscompares = 0;
   int cmp_count = 0;
   int irq_count = 0;

   jcf_top dut (.core_clk(core_clk), .rst(rst), .sw_reg_wr(sw_reg_wr),
      .sw_reg_wdata(sw_reg_wdata), .app_wr(app_wr), .app_addr(app_addr), .app_wdata(app_wdata),
      .cfg_sel(cfg_sel), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .bus_req(bus_req),
      .bus_gnt(bus_gnt), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .code_fifo_level(code_fifo_level), .code_data(code_data), .code_valid(code_valid),
      .field_start(field_start), .field_done(field_done), .irq(irq),
      .entry_index(entry_index), .software_reset_bit(software_reset_bit),
      .guest_bus_oe(guest_bus_oe), .serial_oe(serial_oe), .gpio_oe(gpio_oe));
   jcf_host_mem mdl (.core_clk(core_clk), .rst(rst), .lat(lat), .bus_req(bus_req),
      .bus_gnt(bus_gnt), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("TB: %0d mismatches in %0d comparisons", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic sw_write(input logic v);
      @(posedge core_clk);
      sw_reg_wr <= 1'b1;
      sw_reg_wdata <= v;
      @(posedge core_clk);
      sw_reg_wr <= 1'b0;
      #1;
   endtask

   task automatic app_write(input logic [1:0] a, input logic [31:0] d);
      @(posedge core_clk);
      app_wr <= 1'b1;
      app_addr <= a;
      app_wdata <= d;
      @(posedge core_clk);
      app_wr <= 1'b0;
   endtask

   task automatic cfg(input logic wr, input logic sel, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      cfg_sel <= sel;
      cfg_rd <= !wr;
      cfg_wr <= wr;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge core_clk);
      cfg_rd <= 1'b0;
      cfg_wr <= 1'b0;
      #1;
      ack_v = cfg_ack;
      rd_v = cfg_rdata;
   endtask

   task automatic pulse(input logic s, input logic d);
      @(posedge core_clk);
      field_start <= s;
      field_done <= d;
      @(posedge core_clk);
      field_start <= 1'b0;
      field_done <= 1'b0;
   endtask

   // Seen goes high on any code word, request or access in the span
   task automatic watch(input int n);
      seen = 1'b0;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         seen = seen | code_valid | bus_req | mem_req | irq;
      end
   endtask

   task automatic run_field;
      int n;
      for (int i = 0; i < 4; i++) begin
         n = 0;
         do begin
            @(posedge core_clk);
            #1;
            n++;
         end while (code_valid !== 1'b1 && n < 300);
         cmp(code_data, dat[i]);
      end
   endtask

   // Early release: a grant held three samples must not see the request still up
   // Interrupt pulses are tallied here, since each stands for one cycle only
   always @(posedge core_clk) begin
      gnt_hist <= {gnt_hist[0], bus_gnt};
      if (irq === 1'b1) irq_count <= irq_count + 1;
      if (early_mode && gnt_hist == 2'h3 && bus_gnt) cmp(bus_req, 32'h0);
   end

   initial begin
      #400000;
      miscompares++;
      test_done;
   end

   initial begin
      {rst, sw_reg_wr, sw_reg_wdata, app_wr, cfg_sel, cfg_rd, cfg_wr} = 7'h40;
      {field_start, field_done, early_mode, lat} = 5'h0;
      {app_addr, app_wdata, cfg_addr, cfg_wdata, code_fifo_level} = 82'h0;
      mdl.mem[8'h10] = 32'h80;
      {mdl.mem[8'h11], mdl.mem[8'h12], mdl.mem[8'h13], mdl.mem[8'h00]} = {4{32'h1}};
      {mdl.mem[8'h20], mdl.mem[8'h21], mdl.mem[8'h22], mdl.mem[8'h23]} = {32'hc0, 32'h2, 32'he0, 32'h3};
      {mdl.mem[8'h30], mdl.mem[8'h31], mdl.mem[8'h38], mdl.mem[8'h39]} = {dat[0], dat[1], dat[2], dat[3]};
      cyc(4);
      cmp({guest_bus_oe, serial_oe, bus_req, mem_req, irq}, 32'h0);
      rst <= 1'b0;
      cyc(1);
      cmp({guest_bus_oe, serial_oe, software_reset_bit, gpio_oe}, 32'h600);
      cfg(1'b0, 1'b1, 8'h00, 32'h0);
      cmp(ack_v, 32'h1);
      cmp(rd_v, {`JCF_DEV_ID, `JCF_VEN_ID});
      cfg(1'b1, 1'b1, 8'h04, 32'h6);
      cfg(1'b0, 1'b1, 8'h04, 32'h0);
      cmp(rd_v, 32'h6);
      cfg(1'b0, 1'b1, 8'hfc, 32'h0);
      cmp(rd_v, 32'h0);
      cfg(1'b0, 1'b0, 8'h04, 32'h0);
      cmp(ack_v, 32'h0);
      app_write(2'h0, 32'h40);
      app_write(2'h2, 32'h4);
      watch(20);
      cmp(seen, 32'h0);
      sw_write(1'b1);
      cmp(software_reset_bit, 32'h1);
      app_write(2'h2, 32'h2);
      app_write(2'h0, 32'h40);
      app_write(2'h1, 32'h14);
      code_fifo_level <= 8'h15;
      app_write(2'h2, 32'h4);
      cyc(40);
      watch(10);
      cmp(seen, 32'h0);
      code_fifo_level <= 8'h14;
      run_field;
      pulse(1'b0, 1'b1);
      watch(60);
      cmp(mdl.mem[8'h10], 32'h1);
      cmp({seen, entry_index}, 32'h5);
      cmp(irq_count, 32'h1);
      app_write(2'h2, 32'h1);
      early_mode = 1'b1;
      lat <= 2'h3;
      pulse(1'b1, 1'b0);
      run_field;
      pulse(1'b0, 1'b1);
      watch(60);
      cmp({irq, entry_index}, 32'h1);
      cmp(irq_count, 32'h1);
      mdl.mem[8'h11] = 32'h80;
      pulse(1'b1, 1'b0);
      run_field;
      pulse(1'b0, 1'b1);
      watch(60);
      cmp(mdl.mem[8'h11], 32'h1);
      cmp({seen, entry_index}, 32'h6);
      cmp(irq_count, 32'h2);
      early_mode = 1'b0;
      app_write(2'h2, 32'h2);
      pulse(1'b1, 1'b0);
      watch(30);
      cmp(seen, 32'h0);
      sw_write(1'b0);
      cyc(2);
      cfg(1'b0, 1'b1, 8'h04, 32'h0);
      cmp(rd_v, 32'h6);
      cmp({entry_index, software_reset_bit}, 32'h0);
      sw_write(1'b1);
      app_write(2'h2, 32'h4);
      watch(30);
      cmp(mem_addr, 32'h0);
      cmp(seen, 32'h1);
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      cfg(1'b0, 1'b1, 8'h04, 32'h0);
      cmp(rd_v, 32'h0);
      cmp({entry_index, software_reset_bit, bus_req}, 32'h0);
      test_done;
   end
endmodule
